// *** logic/packet_fifo.sv ***
`timescale 1ns/1ps
// Contract
// R1: byte buffer plus bit shifter; tx MSB first, rx bits packed into bytes
// R2: buffer holds exactly 66 bytes for both directions
// R3: fifo_has_data high iff at least one byte stored
// R4: while reading, fifo_has_data changes only at chip select fall
// R5: queue_at_capacity high exactly when buffer is full
// R6: byte arriving at full buffer is dropped and sets overflow flag
// R7: writing one clears overflow flag and the whole buffer
// R8: frame_tx_done rises after the last packet bit leaves the shifter
// R9: threshold flag re-evaluated only on buffer read or write
// R10: threshold flag high while fill exceeds queue_threshold_value
// R11: threshold flag invalid after full until buffer empties
// R12: host waits for mode_settled after sleep request before access
// R13: keep buffer standby/sleep swaps and standby/sleep into transmit
// R14: keep buffer from receive into standby or sleep
// R15: flush on idle to receive, receive to transmit, leaving transmit
// R16: detect pattern only when enabled, continuous also needs bit sync
// R17: compare shifted bits continuously, set match flag within tolerance
// R18: first bit meets bit 7 of first byte, last meets bit 0
// R19: clear match flag on leaving receive or buffer emptying
// R20: pattern length one to eight bytes, also used for transmit
// R21: accept up to pattern_error_allowance bit mismatches, zero to seven
// R22: pattern from 64-bit value, also sent; host avoids zero bytes
// R23: continuous routing: pin 2 data, pin 1 bit clock on code 00
// R24: packet routing: pin0 checksum/tx done, pin2 has data, 01 payload
// R25: packet rx data shown only between receive_ready and payload_complete
// R26: frame addressing buffer sends all its data bytes to the buffer; code ignores host writes while in receive mode
`include "pfifo_consts.svh"
module packet_fifo import pfifo_pkg::*; (
	input  wire logic     clk_i,
	input  wire logic     sys_rst_i,
	input  wire op_mode_t op_mode_i,
	input  wire logic     packet_mode_i,
	input  wire cfg_t     cfg_i,
	input  wire side_t    side_i,
	input  wire logic     spi_cs_n_i,
	input  wire logic     fifo_frame_i,
	input  wire logic     host_wr_i,
	input  wire logic [7:0] host_wdata_i,
	input  wire logic     host_rd_i,
	input  wire logic     ovf_clear_i,
	input  wire logic     bit_clk_i,
	input  wire logic     rx_bit_i,
	output logic [7:0]    host_rdata_o,
	output logic          tx_bit_o,
	output logic          fifo_has_data_o,
	output logic          queue_at_capacity_o,
	output logic          queue_overflow_flag_o,
	output logic          queue_threshold_flag_o,
	output logic          frame_tx_done_o,
	output logic          pattern_match_flag_o,
	output logic [5:0]    gp_o
);
	logic [7:0]  mem [0:65];
	logic [6:0]  cnt_r, wp_r, rp_r;
	logic [2:0]  clk_s_r, cs_s_r;
	logic [1:0]  rxd_s_r;
	logic [63:0] rsr_r, tsr_r;
	logic [6:0]  tbits_r;
	logic [2:0]  rbits_r;
	logic [7:0]  rbyte_r;
	op_mode_t    mode_r;
	tx_state_t   tx_r;
	logic        reading_r, lvl_blk_r, rx_win_r, prc_r, prr_r, tx_bit_r;
	logic        push, pop, full, flush, bit_rise, bit_fall, cs_fall, tx_pop;
	logic        rx_push, det_on, hit;
	logic [7:0]  push_data;
	logic [6:0]  cnt_nxt, nbits;
	logic [5:0]  gp_nxt;
	// population count of mismatched bits inside the active pattern window
	function automatic logic [6:0] mism(input logic [63:0] sr, input logic [63:0] pv, input logic [2:0] len);
		logic [63:0] d;
		logic [6:0]  n;
		d = (sr ^ (pv >> (7'd56 - {len, 3'b000}))) & ~(64'hffff_ffff_ffff_fffe << {len, 3'b111});
		n = 7'h00;
		for (int i = 0; i < 64; i++)
			n = n + {6'h00, d[i]};
		return n;
	endfunction
	// two-flop synchronisers; stage 2 onward feeds logic, stage 3 is edge history
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			clk_s_r <= 3'h0;
			cs_s_r  <= 3'h7;
			rxd_s_r <= 2'h0;
		end else begin
			clk_s_r <= {clk_s_r[1:0], bit_clk_i};
			cs_s_r  <= {cs_s_r[1:0], spi_cs_n_i};
			rxd_s_r <= {rxd_s_r[0], rx_bit_i};
		end
	end
	assign bit_rise = clk_s_r[1] & ~clk_s_r[2];
	assign bit_fall = ~clk_s_r[1] & clk_s_r[2];
	assign cs_fall  = ~cs_s_r[1] & cs_s_r[2];
	assign full  = (cnt_r == `FIFO_DEPTH); // R2 R5
	assign nbits = {1'b0, cfg_i.pattern_length, 3'b000} + 7'd8; // R20
	// host data only counts inside a frame addressed to the buffer
	assign push = (host_wr_i & fifo_frame_i & (mode_r != M_RX)) | rx_push; // R26
	assign push_data = rx_push ? {rbyte_r[6:0], rxd_s_r[1]} : host_wdata_i; // R1
	assign pop   = ((host_rd_i & fifo_frame_i) | tx_pop) & (cnt_r != 7'h00); // R26
	// buffer flush on overflow clear or mode change; kept transitions fall through untouched
	assign flush = ovf_clear_i // R7
		| (op_mode_i == M_RX && mode_r != M_RX) // R15
		| (op_mode_i == M_TX && mode_r == M_RX) // R15 R13 R14
		| (op_mode_i != M_TX && mode_r == M_TX); // R15

	// fill count with drop on full, push and pop may share a cycle
	always_comb begin
		cnt_nxt = cnt_r;
		if (flush)
			cnt_nxt = `CNT_RST;
		else
			cnt_nxt = cnt_r + {6'h00, push & ~full} - {6'h00, pop}; // R6
	end

	// storage and pointers wrap at the last location
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= `CNT_RST;
			wp_r  <= 7'h00;
			rp_r  <= 7'h00;
			host_rdata_o <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			if (flush) begin
				wp_r <= 7'h00;
				rp_r <= 7'h00;
			end else begin
				if (push & ~full) begin // R1 R6
					mem[wp_r] <= push_data;
					wp_r <= (wp_r == `FIFO_LAST) ? 7'h00 : wp_r + 7'd1;
				end
				if (pop) begin
					host_rdata_o <= mem[rp_r];
					rp_r <= (rp_r == `FIFO_LAST) ? 7'h00 : rp_r + 7'd1;
				end
			end
		end
	end

	// overflow: a clear wins over a new overflow in the same cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			queue_overflow_flag_o <= 1'b0;
		else if (push & full & ~flush)
			queue_overflow_flag_o <= 1'b1; // R6
		else if (ovf_clear_i)
			queue_overflow_flag_o <= 1'b0; // R7
	end

	// during a read burst the flag is frozen so the host never sees it drop mid-byte
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reading_r <= 1'b0;
			fifo_has_data_o <= 1'b0;
			queue_at_capacity_o <= 1'b0;
		end else begin
			if (host_rd_i & fifo_frame_i)
				reading_r <= 1'b1;
			else if (cs_s_r[1])
				reading_r <= 1'b0;
			if (!reading_r || cs_fall)
				fifo_has_data_o <= (cnt_r != 7'h00); // R3 R4
			queue_at_capacity_o <= full; // R5
		end
	end

	// threshold flag moves only on buffer traffic and is blanked after a full event
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			lvl_blk_r <= 1'b0;
			queue_threshold_flag_o <= 1'b0;
		end else begin
			if (cnt_nxt == `FIFO_DEPTH)
				lvl_blk_r <= 1'b1; // R11
			else if (cnt_nxt == 7'h00)
				lvl_blk_r <= 1'b0; // R11
			if (cnt_nxt == `FIFO_DEPTH)
				queue_threshold_flag_o <= 1'b0; // R11
			else if ((push | pop | flush) && !lvl_blk_r)
				queue_threshold_flag_o <= (cnt_nxt > cfg_i.queue_threshold_value); // R9 R10
		end
	end

	assign det_on = cfg_i.pattern_detect_enable & (packet_mode_i | cfg_i.bitsync_on); // R16
	assign hit = mism(rsr_r, cfg_i.pattern_value, cfg_i.pattern_length)
		<= {4'h0, cfg_i.pattern_error_allowance}; // R17 R18 R21
	assign rx_push = bit_rise && packet_mode_i && mode_r == M_RX && pattern_match_flag_o && rbits_r == 3'h7;

	// receive side: bit shifter, pattern comparator and byte packer
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rsr_r   <= 64'h0;
			rbits_r <= 3'h0;
			rbyte_r <= 8'h00;
			pattern_match_flag_o <= 1'b0;
		end else begin
			if (bit_rise && mode_r == M_RX) begin
				rsr_r <= {rsr_r[62:0], rxd_s_r[1]}; // R17
				if (pattern_match_flag_o) begin
					rbyte_r <= {rbyte_r[6:0], rxd_s_r[1]}; // R1
					rbits_r <= rbits_r + 3'h1;
				end
			end
			if (det_on && mode_r == M_RX && op_mode_i == M_RX && !pattern_match_flag_o && hit && !flush)
				pattern_match_flag_o <= 1'b1; // R17
			else if (op_mode_i != M_RX || (cnt_r != 7'h00 && cnt_nxt == 7'h00 && !rx_push))
				pattern_match_flag_o <= 1'b0; // R19
			if (!pattern_match_flag_o)
				rbits_r <= 3'h0;
		end
	end

	assign tx_pop = bit_fall && packet_mode_i && mode_r == M_TX
		&& ((tx_r == TX_SYNC && tbits_r == 7'd1) || (tx_r == TX_DATA && tbits_r == 7'd1));

	// transmit state: pattern first, then buffered bytes until the buffer runs dry
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || mode_r != M_TX || !packet_mode_i) begin
			tx_r    <= TX_IDLE;
			tsr_r   <= 64'h0;
			tbits_r <= 7'h00;
			tx_bit_r <= 1'b0;
		end else if (bit_fall) begin
			unique case (tx_r)
				TX_IDLE: if (cnt_r != 7'h00) begin
					tx_r    <= TX_SYNC;
					tsr_r   <= cfg_i.pattern_value; // R22 R20
					tbits_r <= nbits;
				end
				TX_SYNC, TX_DATA: begin
					if (tbits_r == 7'h00) begin
						tx_r <= TX_DONE; // R8
					end else begin
						tx_bit_r <= tsr_r[63]; // R1
						tsr_r    <= {tsr_r[62:0], 1'b0};
						tbits_r  <= tbits_r - 7'd1;
					end
					if (tbits_r == 7'd1 && cnt_r != 7'h00) begin
						tx_r    <= TX_DATA;
						tsr_r   <= {mem[rp_r], 56'h0};
						tbits_r <= 7'd8;
					end
				end
				TX_DONE: tx_r <= TX_DONE;
			endcase
		end
	end
	assign frame_tx_done_o = (tx_r == TX_DONE); // R8
	assign tx_bit_o = tx_bit_r;

	// mode history and receive data window edges
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_r <= M_SLEEP;
			prr_r <= 1'b0;
			prc_r <= 1'b0;
			rx_win_r <= 1'b0;
		end else begin
			mode_r <= op_mode_i;
			prr_r <= side_i.receive_ready;
			prc_r <= side_i.payload_complete;
			if (side_i.payload_complete & ~prc_r)
				rx_win_r <= 1'b0; // R25
			else if (side_i.receive_ready & ~prr_r)
				rx_win_r <= 1'b1; // R25
		end
	end

	// pin routing per data mode, operating mode and two-bit code
	always_comb begin
		logic rx, tx, dat;
		logic [1:0] c0, c1, c2, c3, c4, c5;
		rx = (mode_r == M_RX);
		tx = (mode_r == M_TX);
		{c5, c4, c3, c2, c1, c0} = cfg_i.pin_route;
		dat = tx ? tx_bit_r : (rxd_s_r[1] & (rx_win_r | ~packet_mode_i)); // R25
		gp_nxt = 6'h00;
		if (packet_mode_i) begin
			unique case (c0) // R24
				`ROUTE_00: gp_nxt[0] = rx ? side_i.checksum_good : tx & frame_tx_done_o;
				`ROUTE_01: gp_nxt[0] = rx ? side_i.payload_complete : tx & side_i.transmit_ready;
				`ROUTE_10: gp_nxt[0] = rx ? pattern_match_flag_o : side_i.low_supply_flag;
				`ROUTE_11: gp_nxt[0] = 1'b0;
			endcase
			unique case (c1)
				`ROUTE_00: gp_nxt[1] = queue_threshold_flag_o;
				`ROUTE_01: gp_nxt[1] = queue_at_capacity_o;
				`ROUTE_10: gp_nxt[1] = fifo_has_data_o;
				`ROUTE_11: gp_nxt[1] = 1'b0;
			endcase
			unique case (c2) // R24
				`ROUTE_00: gp_nxt[2] = fifo_has_data_o;
				`ROUTE_01: gp_nxt[2] = (rx | tx) & dat;
				`ROUTE_10: gp_nxt[2] = side_i.low_supply_flag;
				`ROUTE_11: gp_nxt[2] = side_i.auto_sequence_active;
			endcase
			gp_nxt[3] = (c3 == `ROUTE_00) ? queue_at_capacity_o : (c3 == `ROUTE_10) & rx & pattern_match_flag_o;
		end else begin
			gp_nxt[2] = (rx | tx) & dat; // R23
			gp_nxt[1] = (c1 == `ROUTE_00) & (rx | tx) & clk_s_r[1]; // R23
			gp_nxt[0] = (c0 == `ROUTE_00) ? rx & pattern_match_flag_o : (c0 == `ROUTE_11) & side_i.mode_settled;
			gp_nxt[3] = (c3 == `ROUTE_10) & side_i.auto_sequence_active;
		end
		gp_nxt[4] = (c4 == `ROUTE_10) & side_i.low_supply_flag;
		gp_nxt[5] = (c5 == `ROUTE_11) & side_i.mode_settled;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			gp_o <= 6'h00;
		else
			gp_o <= gp_nxt;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_fill_bound: assert property (cnt_r <= `FIFO_DEPTH) else $error("fill above 66"); // R2
	a_full_flag: assert property (queue_at_capacity_o == $past(cnt_r == `FIFO_DEPTH)) else $error("full flag"); // R5
	a_ovf_set: assert property (push && full && !flush |=> queue_overflow_flag_o && cnt_r == `FIFO_DEPTH)
		else $error("overflow not flagged"); // R6
	a_ovf_clear: assert property (ovf_clear_i && !(push && full) |=> !queue_overflow_flag_o && cnt_r == 7'h00)
		else $error("clear failed"); // R7
	a_tx_flush: assert property (mode_r == M_TX && op_mode_i != M_TX |=> cnt_r == 7'h00) else $error("tx exit kept"); // R15
	a_rx_keep: assert property (mode_r == M_RX && op_mode_i == M_STDBY && !ovf_clear_i && !pop
		|=> cnt_r == $past(cnt_r) + {6'h00, $past(push & ~full)}) else $error("rx data lost"); // R14
	a_thr_still: assert property (!push && !pop && !flush && cnt_nxt != `FIFO_DEPTH |=> $stable(queue_threshold_flag_o))
		else $error("threshold moved alone"); // R9
	a_match_drop: assert property (mode_r == M_RX && op_mode_i != M_RX |=> !pattern_match_flag_o)
		else $error("match kept"); // R19
	a_has_data: assert property (!reading_r && !cs_fall ##1 !reading_r |-> fifo_has_data_o == $past(cnt_r != 7'h00))
		else $error("has data wrong"); // R3
	c_overflow: cover property (push && full);
	c_match: cover property (!pattern_match_flag_o ##1 pattern_match_flag_o);
	c_tx_done: cover property (!frame_tx_done_o ##1 frame_tx_done_o);
endmodule

// *** logic/pfifo_consts.svh ***
`ifndef PFIFO_CONSTS_SVH
`define PFIFO_CONSTS_SVH
`define FIFO_DEPTH   7'd66
`define FIFO_LAST    7'd65
`define CNT_RST      7'h00
`define PAT_BITS     7'd64
`define ROUTE_00     2'h0
`define ROUTE_01     2'h1
`define ROUTE_10     2'h2
`define ROUTE_11     2'h3
`endif

// *** logic/pfifo_pkg.sv ***
package pfifo_pkg;
	typedef enum logic [2:0] {
		M_SLEEP = 3'b000,
		M_STDBY = 3'b001,
		M_FS    = 3'b010,
		M_TX    = 3'b011,
		M_RX    = 3'b100
	} op_mode_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SYNC = 2'b01,
		TX_DATA = 2'b10,
		TX_DONE = 2'b11
	} tx_state_t;
	// pattern and mapping set-up held by the host
	typedef struct packed {
		logic [63:0] pattern_value;
		logic [2:0]  pattern_length;          // bytes minus one
		logic [2:0]  pattern_error_allowance;
		logic        pattern_detect_enable;
		logic        bitsync_on;
		logic [6:0]  queue_threshold_value;
		logic [11:0] pin_route;               // two bits per general pin
	} cfg_t;
	// side signals from the packet handler and control
	typedef struct packed {
		logic checksum_good;
		logic payload_complete;
		logic receive_ready;
		logic transmit_ready;
		logic mode_settled;
		logic low_supply_flag;
		logic auto_sequence_active;
	} side_t;
endpackage

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// host side of the buffer port; it drives just after falling clock edges
module host_model (
	input  wire logic       clk_i,
	input  wire logic       settled_i,
	input  wire logic [7:0] rdata_i,
	output logic            cs_n_o,
	output logic            frame_o,
	output logic            wr_o,
	output logic [7:0]      wdata_o,
	output logic            rd_o,
	output logic            clr_o
);
	initial begin
		{cs_n_o, frame_o, wr_o, rd_o, clr_o} = 5'h10;
		wdata_o = 8'h00;
	end
	// new frame: select must fall again, else the has-data flag stays frozen
	task automatic open_frame();
		@(negedge clk_i);
		cs_n_o = 1'b1;
		frame_o = 1'b0;
		repeat (2) @(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (4) @(negedge clk_i); // select pin is synced inside
		while (settled_i !== 1'b1) @(negedge clk_i);
		frame_o = 1'b1;
	endtask
	task automatic push(input logic [7:0] b);
		@(negedge clk_i);
		wr_o = 1'b1;
		wdata_o = b;
		@(negedge clk_i);
		wr_o = 1'b0;
	endtask
	// one byte per frame so the flag is looked at after every read
	task automatic pop(output logic [7:0] b);
		open_frame();
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		@(negedge clk_i);
		b = rdata_i;
	endtask
	task automatic clear_ovf();
		@(negedge clk_i);
		clr_o = 1'b1;
		@(negedge clk_i);
		clr_o = 1'b0;
	endtask
endmodule

// *** tb/packet_fifo_tb.sv ***
`timescale 1ns/1ps
module packet_fifo_tb import pfifo_pkg::*;;
	logic       clk, rst, pk, bclk, rxb, txb, cs_n, frm, wr, rd, clr;
	logic       has, full, ovf, thr, done, match;
	logic [7:0] wd, rdat, b;
	logic [5:0] gp;
	logic [15:0] w;
	op_mode_t   mode;
	cfg_t       cfg;
	side_t      side;
	int         fails, checked, cyc;
	packet_fifo dut (.clk_i(clk), .sys_rst_i(rst), .op_mode_i(mode), .packet_mode_i(pk), .cfg_i(cfg),
		.side_i(side), .spi_cs_n_i(cs_n), .fifo_frame_i(frm), .host_wr_i(wr), .host_wdata_i(wd),
		.host_rd_i(rd), .ovf_clear_i(clr), .bit_clk_i(bclk), .rx_bit_i(rxb), .host_rdata_o(rdat),
		.tx_bit_o(txb), .fifo_has_data_o(has), .queue_at_capacity_o(full), .queue_overflow_flag_o(ovf),
		.queue_threshold_flag_o(thr), .frame_tx_done_o(done), .pattern_match_flag_o(match), .gp_o(gp));
	host_model h (.clk_i(clk), .settled_i(side.mode_settled), .rdata_i(rdat), .cs_n_o(cs_n),
		.frame_o(frm), .wr_o(wr), .wdata_o(wd), .rd_o(rd), .clr_o(clr));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hang counts as a mismatch and still ends in the report
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle();
		repeat (4) @(negedge clk);
	endtask
	// link clock stands high between frames; bit goes out at the fall
	task automatic link_bit(input logic bi);
		bclk = 1'b0;
		rxb = bi;
		#62.5;
		w = {w[14:0], txb};
		bclk = 1'b1;
		#62.5;
	endtask
	task automatic set_mode(input op_mode_t m);
		@(negedge clk);
		mode = m;
		settle();
	endtask
	initial begin
		{rst, pk, bclk, rxb} = 4'hd;
		fails = 0;
		checked = 0;
		cyc = 0;
		mode = M_STDBY;
		cfg = '0;
		cfg.pattern_value = 64'ha5c3_1122_3344_5566; // no zero bytes
		cfg.pattern_error_allowance = 3'h1;
		cfg.pattern_detect_enable = 1'b1;
		cfg.bitsync_on = 1'b1;
		cfg.queue_threshold_value = 7'h0a;
		side = '0;
		side.mode_settled = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk({has, full, ovf, thr}, 8'h00);
		// fill to capacity, one over
		h.open_frame();
		for (int i = 0; i < 66; i++) begin
			h.push(8'(i + 1));
			if (i == 9 || i == 10) begin
				settle();
				chk(thr, 8'(i == 10));
			end
		end
		settle();
		chk({has, full, thr}, 8'h06);
		h.push(8'hff);
		settle();
		chk(ovf, 8'h01);
		// drain all: order kept, extra byte dropped
		for (int i = 0; i < 66; i++) begin
			h.pop(b);
			chk(b, 8'(i + 1));
			if (i == 0)
				chk(thr, 8'h00);
		end
		settle();
		chk(has, 8'h01);
		h.open_frame();
		chk(has, 8'h00);
		h.clear_ovf();
		settle();
		chk(ovf, 8'h00);
		// threshold works again once emptied; a new value alone moves nothing
		cfg.queue_threshold_value = 7'h00;
		h.push(8'h11);
		settle();
		chk(thr, 8'h01);
		cfg.queue_threshold_value = 7'h05;
		settle();
		chk(thr, 8'h01);
		h.clear_ovf();
		settle();
		chk({has, thr}, 8'h00);
		// standby and sleep keep data, entering receive flushes
		h.push(8'h77);
		set_mode(M_SLEEP);
		set_mode(M_STDBY);
		chk(has, 8'h01);
		set_mode(M_RX);
		chk(has, 8'h00);
		// one bit off the pattern, then one data byte
		for (int i = 0; i < 16; i++)
			link_bit(i < 8 ? 1'(8'ha4 >> (7 - i)) : 1'(8'h3c >> (15 - i)));
		settle();
		chk(match, 8'h01);
		cfg.pin_route = 12'h001;
		side.payload_complete = 1'b1;
		settle();
		chk(gp[0], 8'h01);
		cfg.pin_route = 12'h000;
		set_mode(M_STDBY);
		chk({match, has}, 8'h01);
		h.pop(b);
		chk(b, 8'h3c);
		// preload then transmit: pattern byte, then data
		h.open_frame();
		h.push(8'h3c);
		set_mode(M_TX);
		for (int i = 0; i < 18; i++)
			link_bit(1'b0);
		w = 16'h0000;
		settle();
		chk(done, 8'h01);
		chk(gp[0], 8'h01);
		set_mode(M_STDBY);
		h.push(8'h3c);
		set_mode(M_TX);
		for (int i = 0; i < 17; i++)
			link_bit(1'b0);
		chk(w[15:8], 8'ha5);
		chk(w[7:0], 8'h3c);
		test_done();
	end
endmodule
